// file: lps_sequencer.v
`timescale 1ns/1ps
`include "lps_defs.vh"
module lps_sequencer #(
	parameter LATCH_VARIANT = 1'b0,
	parameter [31:0] OTP_BLANK_CYC = `LPS_OTP_BLANK_CYC,
	parameter [31:0] AUX_SHORT_CYC = `LPS_AUX_SHORT_CYC,
	parameter [31:0] RECOVERY_CYC = `LPS_RECOVERY_CYC,
	parameter [31:0] LL_BLANK_CYC = `LPS_LL_BLANK_CYC,
	parameter REF_W = 12,
	parameter FOLD_W = 8
)(
	// clock and reset
	input wire CLK_I,
	input wire SYS_RST_I,
	// supply comparators
	input wire VCC_ON_I,
	input wire VCC_RESET_I,
	input wire VCC_OVP_I,
	// power stage comparators
	input wire VALLEY_I,
	input wire VALLEY_ABOVE_SHORT_I,
	input wire CS_ABOVE_SETPOINT_I,
	input wire CS_ABOVE_PEAK_LIMIT_I,
	input wire CS_ABOVE_OVERSHOOT_I,
	input wire LINE_ABOVE_HL_I,
	input wire LINE_BELOW_LL_I,
	input wire LIGHT_LOAD_I,
	input wire SETPOINT_CHANGE_I,
	// thermal sense pin comparators
	input wire THERM_BELOW_FOLD_START_I,
	input wire [FOLD_W-1:0] THERM_FOLD_DEPTH_I,
	input wire THERM_BELOW_OTP_OFF_I,
	input wire THERM_ABOVE_OTP_ON_I,
	input wire THERM_ABOVE_OVP_I,
	// amplifier status
	input wire AMP_SINKING_I,
	// power stage controls
	output reg DRV_O,
	output reg LOOP_GROUND_O,
	output reg BOOST_EN_O,
	output reg [REF_W-1:0] CUR_REF_MV_O,
	output reg HIGH_LINE_O,
	output reg [3:0] VALLEY_SEL_O,
	output reg [2:0] FAULT_CAUSE_O,
	output reg RUNNING_O
);

	localparam ST_OFF = 4'b0001;
	localparam ST_RUN = 4'b0010;
	localparam ST_RECOVER = 4'b0100;
	localparam ST_LATCHED = 4'b1000;

	// two-stage synchroniser bank
	localparam NSYNC = 17;
	wire [NSYNC-1:0] raw = {VCC_ON_I, VCC_RESET_I, VCC_OVP_I, VALLEY_I,
		VALLEY_ABOVE_SHORT_I, CS_ABOVE_SETPOINT_I, CS_ABOVE_PEAK_LIMIT_I,
		CS_ABOVE_OVERSHOOT_I, LINE_ABOVE_HL_I, LINE_BELOW_LL_I, LIGHT_LOAD_I,
		SETPOINT_CHANGE_I, THERM_BELOW_FOLD_START_I, THERM_BELOW_OTP_OFF_I,
		THERM_ABOVE_OTP_ON_I, THERM_ABOVE_OVP_I, AMP_SINKING_I};
	reg [NSYNC-1:0] meta_q;
	reg [NSYNC-1:0] sync_q;
	reg [FOLD_W-1:0] fold_meta_q;
	reg [FOLD_W-1:0] fold_q;

	always @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			meta_q <= {NSYNC{1'b0}};
			sync_q <= {NSYNC{1'b0}};
			fold_meta_q <= {FOLD_W{1'b0}};
			fold_q <= {FOLD_W{1'b0}};
		end
		else
		begin
			meta_q <= raw;
			sync_q <= meta_q;
			fold_meta_q <= THERM_FOLD_DEPTH_I;
			fold_q <= fold_meta_q;
		end
	end

	wire vcc_on = sync_q[16];
	wire vcc_reset = sync_q[15];
	wire vcc_ovp = sync_q[14];
	wire valley = sync_q[13];
	wire valley_hi = sync_q[12];
	wire cs_set = sync_q[11];
	wire cs_lim = sync_q[10];
	wire cs_over = sync_q[9];
	wire line_hl = sync_q[8];
	wire line_ll = sync_q[7];
	wire light = sync_q[6];
	wire sp_chg = sync_q[5];
	wire th_fold = sync_q[4];
	wire th_otp = sync_q[3];
	wire th_otp_on = sync_q[2];
	wire th_ovp = sync_q[1];
	wire amp_sink = sync_q[0];

	function [31:0] cnt_step;
		input [31:0] c;
		input [31:0] lim;
		begin
			cnt_step = (c < lim) ? c + 32'h1 : c;
		end
	endfunction

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [31:0] blank_q;
	reg [31:0] aux_q;
	reg [31:0] rec_q;
	reg [31:0] ll_q;
	reg [2:0] ovs_q;
	reg [2:0] cause_q;
	reg [2:0] cause_d;
	reg [3:0] vcount_q;
	reg [3:0] lock_q;
	reg high_q;
	reg valley_d1_q;
	reg line_d1_q;
	reg drv_q;
	reg boost_q;
	reg gnd_q;

	wire running = (state_q == ST_RUN);
	wire blank_done = (blank_q >= OTP_BLANK_CYC);
	wire otp_fault = blank_done & th_otp;
	wire ovp2_fault = th_ovp;
	wire wsc_fault = (ovs_q >= `LPS_OVERSHOOT_LIMIT);
	wire aux_fault = (aux_q >= AUX_SHORT_CYC);
	wire valley_rise = valley & ~valley_d1_q;
	wire line_change = (high_q != line_d1_q);
	wire [3:0] base_valley = high_q ? `LPS_VALLEY_HL : `LPS_VALLEY_LL;

	always @*
	begin
		cause_d = `LPS_CAUSE_NONE;
		if (vcc_ovp)
			cause_d = `LPS_CAUSE_VCCOVP;
		else if (otp_fault)
			cause_d = `LPS_CAUSE_OTP;
		else if (ovp2_fault)
			cause_d = `LPS_CAUSE_OVP2;
		else if (wsc_fault)
			cause_d = `LPS_CAUSE_WSC;
		else if (aux_fault)
			cause_d = `LPS_CAUSE_AUX;
	end

	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (vcc_on)
					state_d = ST_RUN;
			ST_RUN:
				if (cause_d != `LPS_CAUSE_NONE)
				begin
					if (LATCH_VARIANT && cause_d != `LPS_CAUSE_VCCOVP)
						state_d = ST_LATCHED;
					else
						state_d = ST_RECOVER;
				end
				else if (!vcc_on)
					state_d = ST_OFF;
			ST_RECOVER:
				if (rec_q >= RECOVERY_CYC)
				begin
					if (cause_q != `LPS_CAUSE_OTP || th_otp_on)
						state_d = ST_OFF;
				end
			ST_LATCHED:
				if (vcc_reset)
					state_d = ST_OFF;
			default:
				state_d = ST_OFF;
		endcase
	end

	always @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			state_q <= ST_OFF;
			blank_q <= 32'h0;
			aux_q <= 32'h0;
			rec_q <= 32'h0;
			ll_q <= 32'h0;
			ovs_q <= 3'h0;
			cause_q <= `LPS_CAUSE_NONE;
			vcount_q <= 4'h0;
			lock_q <= `LPS_VALLEY_LL;
			high_q <= 1'b0;
			valley_d1_q <= 1'b0;
			line_d1_q <= 1'b0;
			drv_q <= 1'b0;
			boost_q <= 1'b0;
			gnd_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			valley_d1_q <= valley;
			line_d1_q <= high_q;
			// line range detection
			if (line_hl)
			begin
				high_q <= 1'b1;
				ll_q <= 32'h0;
			end
			else if (line_ll)
			begin
				ll_q <= cnt_step(ll_q, LL_BLANK_CYC);
				if (ll_q >= LL_BLANK_CYC)
					high_q <= 1'b0;
			end
			else
				ll_q <= 32'h0;
			// otp blanking restarts at each supply turn-on
			if (state_q == ST_OFF)
				blank_q <= 32'h0;
			else if (running)
				blank_q <= cnt_step(blank_q, OTP_BLANK_CYC);
			// aux short timer counts run time, survives hiccup
			if (valley_hi || state_q == ST_RECOVER || state_q == ST_LATCHED)
				aux_q <= 32'h0;
			else if (running)
				aux_q <= cnt_step(aux_q, AUX_SHORT_CYC);
			if (state_q == ST_RECOVER)
				rec_q <= cnt_step(rec_q, RECOVERY_CYC);
			else
				rec_q <= 32'h0;
			if (running && state_d != ST_RUN && cause_d != `LPS_CAUSE_NONE)
				cause_q <= cause_d;
			else if (state_q == ST_OFF)
				cause_q <= `LPS_CAUSE_NONE;
			// valley selection with lock
			if (line_change || sp_chg)
				lock_q <= base_valley;
			else if (light && lock_q == base_valley)
				lock_q <= base_valley + 4'h1;
			else if (lock_q < base_valley)
				lock_q <= base_valley;
			// switching cycle
			if (!running || state_d != ST_RUN)
			begin
				drv_q <= 1'b0;
				vcount_q <= 4'h0;
			end
			else if (drv_q)
			begin
				if (cs_lim || cs_set)
				begin
					drv_q <= 1'b0;
					vcount_q <= 4'h0;
					if (cs_over)
						ovs_q <= ovs_q + 3'h1;
					else
						ovs_q <= 3'h0;
				end
			end
			else if (valley_rise)
			begin
				if (vcount_q + 4'h1 >= lock_q)
				begin
					drv_q <= 1'b1;
					vcount_q <= 4'h0;
				end
				else
					vcount_q <= vcount_q + 4'h1;
			end
			if (state_q != ST_RUN)
				ovs_q <= 3'h0;
			// loop filter ground on fault, left released on undervoltage stop
			if (state_d == ST_RECOVER || state_d == ST_LATCHED)
				gnd_q <= 1'b1;
			else if (state_d == ST_RUN)
				gnd_q <= 1'b0;
			// start-up boost
			if (state_q == ST_OFF && state_d == ST_RUN && gnd_q)
				boost_q <= 1'b1;
			else if (amp_sink || state_d != ST_RUN)
				boost_q <= 1'b0;
		end
	end

	// reference with thermal foldback
	function [REF_W-1:0] fold_ref;
		input fold_on;
		input [FOLD_W-1:0] depth;
		reg [REF_W+FOLD_W-1:0] cut;
		begin
			cut = ({{FOLD_W{1'b0}}, `LPS_VREF_NOM_MV} * {{REF_W{1'b0}}, depth})
				>> (FOLD_W + `LPS_FOLD_FLOOR_SHIFT);
			fold_ref = fold_on ? `LPS_VREF_NOM_MV - cut[REF_W-1:0] : `LPS_VREF_NOM_MV;
		end
	endfunction

	always @(posedge CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			DRV_O <= 1'b0;
			LOOP_GROUND_O <= 1'b1;
			BOOST_EN_O <= 1'b0;
			CUR_REF_MV_O <= `LPS_VREF_NOM_MV;
			HIGH_LINE_O <= 1'b0;
			VALLEY_SEL_O <= `LPS_VALLEY_LL;
			FAULT_CAUSE_O <= `LPS_CAUSE_NONE;
			RUNNING_O <= 1'b0;
		end
		else
		begin
			DRV_O <= drv_q & ~(cs_lim | cs_set);
			LOOP_GROUND_O <= gnd_q;
			BOOST_EN_O <= boost_q;
			CUR_REF_MV_O <= fold_ref(th_fold, fold_q);
			HIGH_LINE_O <= high_q;
			VALLEY_SEL_O <= lock_q;
			FAULT_CAUSE_O <= cause_q;
			RUNNING_O <= running;
		end
	end

endmodule

// file: lps_defs.vh
`ifndef LPS_DEFS_VH
`define LPS_DEFS_VH

// clock rate in kHz (200 MHz)
`define LPS_CLK_KHZ 200000
// otp blanking at start, microseconds (least time, rounds up)
`define LPS_OTP_BLANK_US 250
`define LPS_OTP_BLANK_CYC ((`LPS_OTP_BLANK_US * `LPS_CLK_KHZ + 999) / 1000)
// aux short timer, milliseconds
`define LPS_AUX_SHORT_MS 90
`define LPS_AUX_SHORT_CYC (`LPS_AUX_SHORT_MS * `LPS_CLK_KHZ)
// auto-recovery off interval, seconds
`define LPS_RECOVERY_S 4
`define LPS_RECOVERY_CYC (`LPS_RECOVERY_S * 1000 * `LPS_CLK_KHZ)
// low-line blanking, milliseconds
`define LPS_LL_BLANK_MS 25
`define LPS_LL_BLANK_CYC (`LPS_LL_BLANK_MS * `LPS_CLK_KHZ)
// consecutive overshoot cycles before winding short fault
`define LPS_OVERSHOOT_LIMIT 3'h4
// nominal current reference, millivolts
`define LPS_VREF_NOM_MV 12'h0fa
// foldback floor is half the programmed value
`define LPS_FOLD_FLOOR_SHIFT 1
// valley index at low line and at high line
`define LPS_VALLEY_LL 4'h1
`define LPS_VALLEY_HL 4'h2
// fault cause codes
`define LPS_CAUSE_NONE 3'h0
`define LPS_CAUSE_OTP 3'h1
`define LPS_CAUSE_OVP2 3'h2
`define LPS_CAUSE_WSC 3'h3
`define LPS_CAUSE_AUX 3'h4
`define LPS_CAUSE_VCCOVP 3'h5

`endif

// file: lps_power_model.sv
`timescale 1ns/1ps
module lps_power_model #(
	parameter int ON_CYC = 12,
	parameter int OFF_CYC = 4
)(
	// clock and gate drive
	input wire logic clk_i,
	input wire logic drv_i,
	// forces a shorted auxiliary winding
	input wire logic short_i,
	// comparator outputs
	output logic valley_o,
	output logic above_short_o,
	output logic cs_set_o
);
	logic drv_q;
	int n_q;
	initial
	begin
		drv_q = 1'b0;
		n_q = 0;
		valley_o = 1'b0;
		above_short_o = 1'b0;
		cs_set_o = 1'b0;
	end
	// ramp while on, ringing valleys while off
	always @(posedge clk_i)
	begin
		drv_q <= drv_i;
		n_q <= (drv_i != drv_q) ? 0 : n_q + 1;
		cs_set_o <= drv_i && n_q >= ON_CYC;
		valley_o <= !drv_i && (n_q % OFF_CYC) == OFF_CYC - 1;
		above_short_o <= !drv_i && !short_i && n_q < OFF_CYC;
	end
endmodule

// file: lps_sequencer_checker.sv
`timescale 1ns/1ps
module lps_checker (
	input wire CLK_I,
	input wire SYS_RST_I,
	input wire CS_ABOVE_SETPOINT_I,
	input wire CS_ABOVE_PEAK_LIMIT_I,
	input wire LINE_ABOVE_HL_I,
	input wire THERM_BELOW_FOLD_START_I,
	input wire AMP_SINKING_I,
	input wire DRV_O,
	input wire LOOP_GROUND_O,
	input wire BOOST_EN_O,
	input wire [11:0] CUR_REF_MV_O,
	input wire HIGH_LINE_O,
	input wire [3:0] VALLEY_SEL_O,
	input wire [2:0] FAULT_CAUSE_O,
	input wire RUNNING_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	a_peak_ends_on: assert property (CS_ABOVE_PEAK_LIMIT_I |-> ##[1:5] !DRV_O)
		else $error("drive kept past peak limit");
	a_setpoint_ends_on: assert property (CS_ABOVE_SETPOINT_I |-> ##[1:5] !DRV_O)
		else $error("drive kept past setpoint");
	a_fault_grounds_loop: assert property (($changed(FAULT_CAUSE_O) && FAULT_CAUSE_O != 3'h0)
		|-> ##[0:2] (LOOP_GROUND_O && !RUNNING_O))
		else $error("fault without loop ground or stop");
	a_stop_ends_drive: assert property ($fell(RUNNING_O) |-> ##[0:2] !DRV_O)
		else $error("drive after stop");
	a_ref_nominal: assert property (!THERM_BELOW_FOLD_START_I [*8] |-> CUR_REF_MV_O == 12'h0fa)
		else $error("reference not nominal");
	a_ref_floor: assert property (CUR_REF_MV_O >= 12'h07d)
		else $error("reference below half");
	a_high_line_fast: assert property (LINE_ABOVE_HL_I [*5] |-> HIGH_LINE_O)
		else $error("high line late");
	a_valley_high_line: assert property ($rose(HIGH_LINE_O) |-> ##[1:60] VALLEY_SEL_O >= 4'h2)
		else $error("first valley at high line");
	a_boost_released: assert property (AMP_SINKING_I [*6] |-> !BOOST_EN_O)
		else $error("boost on while sinking");
endmodule
bind lps_sequencer lps_checker chk_u (
	.CLK_I(CLK_I),
	.SYS_RST_I(SYS_RST_I),
	.CS_ABOVE_SETPOINT_I(CS_ABOVE_SETPOINT_I),
	.CS_ABOVE_PEAK_LIMIT_I(CS_ABOVE_PEAK_LIMIT_I),
	.LINE_ABOVE_HL_I(LINE_ABOVE_HL_I),
	.THERM_BELOW_FOLD_START_I(THERM_BELOW_FOLD_START_I),
	.AMP_SINKING_I(AMP_SINKING_I),
	.DRV_O(DRV_O),
	.LOOP_GROUND_O(LOOP_GROUND_O),
	.BOOST_EN_O(BOOST_EN_O),
	.CUR_REF_MV_O(CUR_REF_MV_O),
	.HIGH_LINE_O(HIGH_LINE_O),
	.VALLEY_SEL_O(VALLEY_SEL_O),
	.FAULT_CAUSE_O(FAULT_CAUSE_O),
	.RUNNING_O(RUNNING_O)
);

// file: test_lps_sequencer.sv
`timescale 1ns/1ps
module test_lps_sequencer;
	reg CLK_I = 1'b0, SYS_RST_I = 1'b1, VCC_ON_I = 1'b0, VCC_RESET_I = 1'b0, LIGHT_LOAD_I = 1'b0;
	reg CS_ABOVE_PEAK_LIMIT_I = 1'b0, LINE_ABOVE_HL_I = 1'b0, LINE_BELOW_LL_I = 1'b0;
	reg SETPOINT_CHANGE_I = 1'b0, THERM_BELOW_FOLD_START_I = 1'b0, AMP_SINKING_I = 1'b0;
	reg THERM_ABOVE_OTP_ON_I = 1'b1;
	reg [7:0] THERM_FOLD_DEPTH_I = 8'h00;
	reg [4:0] f = 5'h00;
	wire THERM_BELOW_OTP_OFF_I = f[0];
	wire THERM_ABOVE_OVP_I = f[1];
	wire CS_ABOVE_OVERSHOOT_I = f[2];
	wire VCC_OVP_I = f[3];
	wire VALLEY_I, VALLEY_ABOVE_SHORT_I, CS_ABOVE_SETPOINT_I, DRV_O, LOOP_GROUND_O;
	wire BOOST_EN_O, HIGH_LINE_O, RUNNING_O;
	wire [11:0] CUR_REF_MV_O;
	wire [3:0] VALLEY_SEL_O;
	wire [2:0] FAULT_CAUSE_O;
	logic [2:0] exp_c [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
	int fails = 0, n_tests = 0, i, k;
	always #2.5 CLK_I = ~CLK_I;
	lps_sequencer #(.OTP_BLANK_CYC(20), .AUX_SHORT_CYC(200), .RECOVERY_CYC(300),
		.LL_BLANK_CYC(50)) DUT (.*);
	lps_power_model #(.ON_CYC(12), .OFF_CYC(4)) model (.clk_i(CLK_I), .drv_i(DRV_O),
		.short_i(f[4]), .valley_o(VALLEY_I), .above_short_o(VALLEY_ABOVE_SHORT_I),
		.cs_set_o(CS_ABOVE_SETPOINT_I));
	task cyc(input int n);
		repeat (n) @(posedge CLK_I);
	endtask
	task chk(input string s, input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task t_start;
		VCC_ON_I <= 1'b1;
		f[0] <= 1'b1;
		cyc(12);
		chk("otp_blank", 0, FAULT_CAUSE_O);
		chk("boost", 1, BOOST_EN_O);
		chk("ref", 12'h0fa, CUR_REF_MV_O);
		f[0] <= 1'b0;
		AMP_SINKING_I <= 1'b1;
		cyc(8);
		chk("boost", 0, BOOST_EN_O);
	endtask
	task t_peak;
		for (i = 0; i < 200 && DRV_O !== 1'b1; i++) cyc(1);
		CS_ABOVE_PEAK_LIMIT_I <= 1'b1;
		for (i = 0; i < 40 && DRV_O === 1'b1; i++) cyc(1);
		chk("peak_off", 1, i < 6);
		CS_ABOVE_PEAK_LIMIT_I <= 1'b0;
	endtask
	task t_uvlo;
		VCC_ON_I <= 1'b0;
		VCC_RESET_I <= 1'b1;
		cyc(8);
		chk("uvlo_run", 0, RUNNING_O);
		chk("uvlo_loop", 0, LOOP_GROUND_O);
		VCC_ON_I <= 1'b1;
		VCC_RESET_I <= 1'b0;
		cyc(8);
		chk("retry", 1, RUNNING_O);
	endtask
	task t_line;
		LINE_ABOVE_HL_I <= 1'b1;
		cyc(6);
		chk("high_line", 1, HIGH_LINE_O);
		cyc(40);
		chk("valley", 2, VALLEY_SEL_O);
		LINE_ABOVE_HL_I <= 1'b0;
		LINE_BELOW_LL_I <= 1'b1;
		cyc(30);
		chk("ll_blank", 1, HIGH_LINE_O);
		cyc(40);
		chk("low_line", 0, HIGH_LINE_O);
		LIGHT_LOAD_I <= 1'b1;
		cyc(40);
		chk("light", 2, VALLEY_SEL_O);
		LIGHT_LOAD_I <= 1'b0;
		cyc(40);
		chk("locked", 2, VALLEY_SEL_O);
		SETPOINT_CHANGE_I <= 1'b1;
		cyc(1);
		SETPOINT_CHANGE_I <= 1'b0;
		cyc(40);
		chk("unlock", 1, VALLEY_SEL_O);
	endtask
	task t_fold;
		THERM_BELOW_FOLD_START_I <= 1'b1;
		THERM_FOLD_DEPTH_I <= 8'hff;
		cyc(200);
		chk("fold", 1, CUR_REF_MV_O >= 12'h07d && CUR_REF_MV_O < 12'h0fa);
		THERM_BELOW_FOLD_START_I <= 1'b0;
		cyc(200);
		chk("ref", 12'h0fa, CUR_REF_MV_O);
	endtask
	task t_fault(input int n, input logic [2:0] e);
		f <= 5'h01 << n;
		// otp recovery also needs the pin back above its recovery level
		THERM_ABOVE_OTP_ON_I <= (n != 0);
		for (i = 0; i < 600 && FAULT_CAUSE_O !== e; i++) cyc(1);
		cyc(2);
		chk("cause", e, FAULT_CAUSE_O);
		chk("loop_gnd", 1, LOOP_GROUND_O);
		chk("drv", 0, DRV_O);
		f <= 5'h00;
		// grounded loop filter: amplifier sources again
		AMP_SINKING_I <= 1'b0;
		cyc(250);
		chk("still_off", 0, RUNNING_O);
		if (n == 0)
		begin
			cyc(100);
			chk("otp_hold", 0, RUNNING_O);
			THERM_ABOVE_OTP_ON_I <= 1'b1;
		end
		for (i = 0; i < 300 && RUNNING_O !== 1'b1; i++) cyc(1);
		chk("resume", 1, RUNNING_O);
		chk("boost_restart", 1, BOOST_EN_O);
		AMP_SINKING_I <= 1'b1;
	endtask
	task t_hiccup;
		f <= 5'h10;
		cyc(120);
		VCC_ON_I <= 1'b0;
		cyc(20);
		VCC_ON_I <= 1'b1;
		// paused timer trips well before a fresh 200-cycle count
		for (i = 0; i < 130 && FAULT_CAUSE_O !== 3'h4; i++) cyc(1);
		chk("hiccup_aux", 4, FAULT_CAUSE_O);
		f <= 5'h00;
		AMP_SINKING_I <= 1'b0;
		for (i = 0; i < 400 && RUNNING_O !== 1'b1; i++) cyc(1);
		chk("hiccup_resume", 1, RUNNING_O);
		AMP_SINKING_I <= 1'b1;
		cyc(8);
	endtask
	initial
	begin
		cyc(4);
		SYS_RST_I <= 1'b0;
		cyc(2);
		t_start;
		t_peak;
		t_uvlo;
		t_line;
		t_fold;
		for (k = 0; k < 5; k++) t_fault(k, exp_c[k]);
		t_hiccup;
		print_verdict;
	end
	initial
	begin
		#200000;
		fails++;
		print_verdict;
	end
endmodule
